// ==== verilog/ilm_latency_meter.sv ====
// Functional notes
// R1: Latency measured in own clock cycles
// R2: Counting starts on rising line edge
// R3: Counter zeroed at start, result kept
// R4: Result loaded only after counter stops
// R5: Configured count of identical line counters
// R6: Level or pulse mode by configuration
// R7: Newest measurement overwrites older result
// R8: Registers are 32-bit words, word addressed
// R9: Control group fixed at 0x20 to 0x24
// R10: Results at 0x0..0x1f in line order
// R11: Invalid offsets read as zero
// R12: Only control bit 0 writable
// R13: Global enable resets to zero
// R14: Pulse mode stop via halt bits
// R15: Level mode stops when line falls
// R16: Valid set on load, cleared on read
// R17: Unconfigured lines never start, read zero
`timescale 1ns/1ps
`default_nettype none
module ilm_latency_meter #(
    parameter int NUM_LINES = 32,
    parameter int PULSE_MODE = 0,
    parameter int CLOCK_HZ = ilm_pkg::ILM_CLOCK_HZ,
    parameter logic [23:0] REVISION = 24'h000001 // Arbitrary value
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output var logic [31:0] readdata,
    output logic waitrequest,
    // Interrupt lines under measurement
    input wire logic [31:0] irq
);
    localparam int N = ilm_pkg::ILM_MAX_LINES;

    logic enable;
    logic [31:0] halt_bits;
    logic [31:0] valid_bits;
    logic [31:0] active_bits;
    logic [31:0] done_bits;
    logic [31:0] result [N];
    logic [31:0] count [N];
    logic [31:0] next_readdata;
    logic [31:0] control_word;
    logic access_done;
    logic rd_hit;

    // One access per request, answered one cycle after it is seen
    assign waitrequest = (read || write) && !access_done;
    assign rd_hit = read && !access_done;

    always_ff @(posedge mclk) begin
        if (reset) begin
            access_done <= 1'b0;
        end else begin
            access_done <= (read || write) && !access_done;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_line
            if (g < NUM_LINES) begin : gen_used // [R5]
                ilm_line_if ln();
                assign ln.enable = enable;
                assign ln.irq = irq[g];
                assign ln.halt = halt_bits[g];
                ilm_counter #(.PULSE_MODE(PULSE_MODE)) u_counter (
                    .mclk(mclk),
                    .reset(reset),
                    .ln(ln)
                ); // [R6]
                assign active_bits[g] = ln.active;
                assign done_bits[g] = ln.done;
                assign count[g] = ln.count;
            end else begin : gen_unused
                assign active_bits[g] = 1'b0; // [R17]
                assign done_bits[g] = 1'b0;
                assign count[g] = 32'h0000_0000;
            end

            always_ff @(posedge mclk) begin
                if (reset) begin
                    result[g] <= 32'h0000_0000;
                end else if (done_bits[g]) begin
                    result[g] <= count[g]; // [R4] [R7]
                end
            end

            // Set wins over the read clear
            always_ff @(posedge mclk) begin
                if (reset) begin
                    valid_bits[g] <= 1'b0;
                end else if (done_bits[g]) begin
                    valid_bits[g] <= 1'b1; // [R16]
                end else if (rd_hit && address == 6'(g)) begin
                    valid_bits[g] <= 1'b0; // [R16]
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (reset) begin
            enable <= ilm_pkg::ILM_ENABLE_RESET; // [R13]
            halt_bits <= 32'h0000_0000;
        end else if (write && !access_done) begin
            if (address == ilm_pkg::ILM_OFS_CONTROL) begin
                enable <= writedata[ilm_pkg::ILM_CTL_ENABLE_BIT]; // [R12]
            end
            if (address == ilm_pkg::ILM_OFS_HALT) begin
                halt_bits <= writedata; // [R14]
            end
        end
    end

    always_comb begin
        control_word = ilm_pkg::ILM_ZERO_WORD;
        control_word[ilm_pkg::ILM_CTL_ENABLE_BIT] = enable;
        control_word[ilm_pkg::ILM_CTL_TYPE_BIT] = (PULSE_MODE != 0);
        control_word[ilm_pkg::ILM_CTL_COUNT_LSB +: ilm_pkg::ILM_CTL_COUNT_W] =
            ilm_pkg::ILM_CTL_COUNT_W'(NUM_LINES);
        control_word[ilm_pkg::ILM_CTL_REV_LSB +: ilm_pkg::ILM_CTL_REV_W] = REVISION;
    end

    always_comb begin
        next_readdata = ilm_pkg::ILM_ZERO_WORD; // [R11]
        if (address <= ilm_pkg::ILM_OFS_RESULT_LAST) begin
            if (32'(address) < 32'(NUM_LINES)) begin
                next_readdata = result[address[4:0]]; // [R10]
            end
        end else begin
            case (address) // [R9] [R8]
                ilm_pkg::ILM_OFS_CONTROL: next_readdata = control_word;
                ilm_pkg::ILM_OFS_FREQ: next_readdata = 32'(CLOCK_HZ);
                ilm_pkg::ILM_OFS_HALT: next_readdata = halt_bits;
                ilm_pkg::ILM_OFS_VALID: next_readdata = valid_bits;
                ilm_pkg::ILM_OFS_ACTIVE: next_readdata = active_bits;
                default: next_readdata = ilm_pkg::ILM_ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if (rd_hit) begin
            readdata <= next_readdata;
        end
    end

    // Line 0, enable and handshake checks
    a_enable_reset: assert property (@(posedge mclk) $fell(reset) |-> !enable) // [R13]
        else $error("enable not clear after reset");
    a_result_load: assert property (@(posedge mclk) disable iff (reset) // [R4]
        done_bits[0] |=> result[0] == $past(count[0]))
        else $error("result not loaded from counter");
    a_valid_set: assert property (@(posedge mclk) disable iff (reset) // [R16]
        done_bits[0] |=> valid_bits[0])
        else $error("valid not set on load");
    a_start_zero: assert property (@(posedge mclk) disable iff (reset) // [R3]
        $rose(active_bits[0]) |-> count[0] == 32'h0000_0000)
        else $error("counter not zeroed at start");
    a_no_start_off: assert property (@(posedge mclk) disable iff (reset) // [R13]
        !enable && !active_bits[0] |=> !active_bits[0])
        else $error("counter started while disabled");
    a_level_stop: assert property (@(posedge mclk) disable iff (reset) // [R15]
        PULSE_MODE == 0 && active_bits[0] && !irq[0] |=> done_bits[0] && !active_bits[0])
        else $error("level mode did not stop");
    a_count_step: assert property (@(posedge mclk) disable iff (reset) // [R1]
        active_bits[0] && $past(active_bits[0]) && !done_bits[0] |=>
        !active_bits[0] || count[0] == $past(count[0]) + 32'h0000_0001)
        else $error("counter did not advance");
    a_result_hold: assert property (@(posedge mclk) disable iff (reset) // [R3]
        !done_bits[0] |=> $stable(result[0]))
        else $error("result changed without stop");
    a_wait_one: assert property (@(posedge mclk) disable iff (reset) // [R8]
        read && waitrequest |=> !waitrequest || !read)
        else $error("access not answered in one cycle");

    // Register bus checks
    a_reset_clear: assert property (@(posedge mclk) // [R13]
        $fell(reset) |->
        readdata == 32'h0000_0000 && halt_bits == 32'h0000_0000 &&
        valid_bits == 32'h0000_0000 && active_bits == 32'h0000_0000)
        else $error("register state not clear after reset");
    a_read_zero: assert property (@(posedge mclk) disable iff (reset) // [R11]
        rd_hit && address > ilm_pkg::ILM_OFS_ACTIVE |=>
        readdata == ilm_pkg::ILM_ZERO_WORD)
        else $error("invalid offset did not read zero");
    a_read_unused: assert property (@(posedge mclk) disable iff (reset) // [R10] [R11]
        rd_hit && address <= ilm_pkg::ILM_OFS_RESULT_LAST && 32'(address) >= 32'(NUM_LINES) |=>
        readdata == ilm_pkg::ILM_ZERO_WORD)
        else $error("unconfigured result slot not zero");
    a_read_freq: assert property (@(posedge mclk) disable iff (reset) // [R9]
        rd_hit && address == ilm_pkg::ILM_OFS_FREQ |=>
        readdata == 32'(CLOCK_HZ))
        else $error("frequency word wrong");
    a_read_count: assert property (@(posedge mclk) disable iff (reset) // [R5] [R12]
        rd_hit && address == ilm_pkg::ILM_OFS_CONTROL |=>
        readdata[ilm_pkg::ILM_CTL_COUNT_LSB +: ilm_pkg::ILM_CTL_COUNT_W] == 6'(NUM_LINES))
        else $error("line count field wrong");
    a_read_halt: assert property (@(posedge mclk) disable iff (reset) // [R14]
        rd_hit && address == ilm_pkg::ILM_OFS_HALT |=>
        readdata == $past(halt_bits))
        else $error("halt word read wrong");
    a_read_valid: assert property (@(posedge mclk) disable iff (reset) // [R16]
        rd_hit && address == ilm_pkg::ILM_OFS_VALID |=>
        readdata == $past(valid_bits))
        else $error("valid word read wrong");
    a_enable_write: assert property (@(posedge mclk) disable iff (reset) // [R12]
        write && !access_done && address == ilm_pkg::ILM_OFS_CONTROL |=>
        enable == $past(writedata[ilm_pkg::ILM_CTL_ENABLE_BIT]))
        else $error("enable bit not written");
    a_halt_write: assert property (@(posedge mclk) disable iff (reset) // [R14]
        write && !access_done && address == ilm_pkg::ILM_OFS_HALT |=>
        halt_bits == $past(writedata))
        else $error("halt bits not written");
    a_no_write_ro: assert property (@(posedge mclk) disable iff (reset) // [R12]
        write && !access_done && address != ilm_pkg::ILM_OFS_CONTROL &&
        address != ilm_pkg::ILM_OFS_HALT |=> $stable(enable) && $stable(halt_bits))
        else $error("read-only offset took a write");
    a_wait_first: assert property (@(posedge mclk) disable iff (reset) // [R8]
        $rose(read || write) |->
        waitrequest)
        else $error("new access not held for one cycle");
    a_rd_one: assert property (@(posedge mclk) disable iff (reset) // [R8]
        rd_hit |=>
        !rd_hit)
        else $error("one request read twice");

    // Every configured line gets the same checks
    generate
        for (g = 0; g < NUM_LINES; g++) begin : gen_check
            a_line_load: assert property (@(posedge mclk) disable iff (reset) // [R4] [R7]
                done_bits[g] |=>
                result[g] == $past(count[g]))
                else $error("line result not loaded");
            a_line_valid: assert property (@(posedge mclk) disable iff (reset) // [R16]
                done_bits[g] |=>
                valid_bits[g])
                else $error("line valid not set");
            a_line_clear: assert property (@(posedge mclk) disable iff (reset) // [R16]
                rd_hit && address == 6'(g) && !done_bits[g] |=>
                !valid_bits[g])
                else $error("line valid not cleared by read");
            a_line_hold: assert property (@(posedge mclk) disable iff (reset) // [R3]
                !done_bits[g] |=>
                $stable(result[g]))
                else $error("line result changed without stop");
            a_line_zero: assert property (@(posedge mclk) disable iff (reset) // [R3]
                $rose(active_bits[g]) |->
                count[g] == 32'h0000_0000)
                else $error("line counter not zeroed");
            a_line_step: assert property (@(posedge mclk) disable iff (reset) // [R1]
                active_bits[g] && $stable(irq[g]) &&
                (PULSE_MODE == 0 ? irq[g] : !$rose(halt_bits[g])) |=>
                count[g] == $past(count[g]) + 32'h0000_0001)
                else $error("line counter did not advance");
            a_line_idle: assert property (@(posedge mclk) disable iff (reset) // [R13]
                !enable && !active_bits[g] |=>
                !active_bits[g])
                else $error("line started while disabled");
            a_line_done: assert property (@(posedge mclk) disable iff (reset) // [R4]
                done_bits[g] |->
                !active_bits[g] ##1 !done_bits[g])
                else $error("line stop not a single pulse");
            a_line_level: assert property (@(posedge mclk) disable iff (reset) // [R14] [R15]
                PULSE_MODE == 0 && active_bits[g] && irq[g] |=>
                active_bits[g])
                else $error("level line stopped while high");
            a_line_pulse: assert property (@(posedge mclk) disable iff (reset) // [R14]
                PULSE_MODE != 0 && active_bits[g] && $rose(halt_bits[g]) && $stable(irq[g]) |=>
                done_bits[g] && !active_bits[g])
                else $error("pulse line ignored halt");
            a_line_keep: assert property (@(posedge mclk) disable iff (reset) // [R14]
                PULSE_MODE != 0 && active_bits[g] && !halt_bits[g] |=>
                active_bits[g])
                else $error("pulse line stopped without halt");
        end

        for (g = NUM_LINES; g < N; g++) begin : gen_quiet
            a_unused_quiet: assert property (@(posedge mclk) disable iff (reset) // [R17]
                !active_bits[g] && !valid_bits[g] && result[g] == 32'h0000_0000)
                else $error("unconfigured line not idle");
        end
    endgenerate

    // Main scenarios to be reached
    c_measure: cover property (@(posedge mclk) disable iff (reset) done_bits[0]);
    c_read_valid: cover property (@(posedge mclk) disable iff (reset)
        rd_hit && address == ilm_pkg::ILM_OFS_VALID);
    c_enable_write: cover property (@(posedge mclk) disable iff (reset) $rose(enable));
    c_pulse_stop: cover property (@(posedge mclk) disable iff (reset)
        PULSE_MODE != 0 && done_bits[0]);
    c_unused_read: cover property (@(posedge mclk) disable iff (reset)
        rd_hit && address <= ilm_pkg::ILM_OFS_RESULT_LAST && 32'(address) >= 32'(NUM_LINES));
endmodule
`default_nettype wire

// ==== verilog/ilm_pkg.sv ====
package ilm_pkg;
    localparam int ILM_ADDR_W = 6;
    localparam logic [5:0] ILM_OFS_RESULT_LAST = 6'h1f;
    localparam logic [5:0] ILM_OFS_CONTROL = 6'h20;
    localparam logic [5:0] ILM_OFS_FREQ = 6'h21;
    localparam logic [5:0] ILM_OFS_HALT = 6'h22;
    localparam logic [5:0] ILM_OFS_VALID = 6'h23;
    localparam logic [5:0] ILM_OFS_ACTIVE = 6'h24;
    localparam int ILM_CTL_ENABLE_BIT = 0;
    localparam int ILM_CTL_TYPE_BIT = 1;
    localparam int ILM_CTL_COUNT_LSB = 2;
    localparam int ILM_CTL_COUNT_W = 6;
    localparam int ILM_CTL_REV_LSB = 8;
    localparam int ILM_CTL_REV_W = 24;
    localparam logic ILM_ENABLE_RESET = 1'h0;
    localparam logic [31:0] ILM_ZERO_WORD = 32'h0000_0000;
    localparam int ILM_CLOCK_HZ = 50000000;
    localparam int ILM_MAX_LINES = 32;
    localparam int ILM_TYPE_LEVEL = 0;
    localparam int ILM_TYPE_PULSE = 1;
endpackage

// ==== verilog/ilm_line_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ilm_line_if;
    logic enable;
    logic irq;
    logic halt;
    logic active;
    logic done;
    logic [31:0] count;
    modport meter(input enable, input irq, input halt, output active, output done, output count);
    modport ctrl(output enable, output irq, output halt, input active, input done, input count);
endinterface
`default_nettype wire

// ==== verilog/ilm_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module ilm_counter #(
    parameter int PULSE_MODE = 0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Line controls and results
    ilm_line_if.meter ln
);
    logic irq_q;
    logic halt_q;
    logic rise;
    logic stop;

    assign rise = ln.enable && ln.irq && !irq_q;
    // Level mode stops on falling line, pulse mode on the halt bit
    assign stop = ln.active && ((PULSE_MODE == 0) ? !ln.irq : (ln.halt && !halt_q));

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_q <= 1'b0;
            halt_q <= 1'b0;
        end else begin
            irq_q <= ln.irq;
            halt_q <= ln.halt;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ln.active <= 1'b0;
            ln.count <= 32'h0000_0000;
            ln.done <= 1'b0;
        end else begin
            ln.done <= 1'b0;
            if (rise) begin // [R2] [R3]
                ln.active <= 1'b1;
                ln.count <= 32'h0000_0000;
            end else if (stop) begin // [R15] [R14]
                ln.active <= 1'b0;
                ln.done <= 1'b1;
            end else if (ln.active) begin
                ln.count <= ln.count + 32'h0000_0001; // [R1]
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/ilm_irq_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module ilm_irq_source (
    // Clock
    input wire logic mclk,
    // Interrupt lines
    output var logic [31:0] irq
);
    initial irq = 32'h0;
    // Hold one line high for len cycles, then return it low
    task automatic pulse(input int line, input int len);
        @(negedge mclk);
        irq[line] = 1'b1;
        repeat (len) @(negedge mclk);
        irq[line] = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== sim/ilm_latency_meter_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module ilm_latency_meter_bench;
    localparam logic [5:0] CTL = ilm_pkg::ILM_OFS_CONTROL;
    localparam logic [5:0] FRQ = ilm_pkg::ILM_OFS_FREQ;
    localparam logic [5:0] HLT = ilm_pkg::ILM_OFS_HALT;
    localparam logic [5:0] VLD = ilm_pkg::ILM_OFS_VALID;
    localparam logic [5:0] ACT = ilm_pkg::ILM_OFS_ACTIVE;
    logic mclk, reset, read, write;
    logic [5:0] address;
    logic [31:0] writedata, rdata;
    wire logic [31:0] readdata, readdata_p, irq;
    wire logic waitrequest, waitrequest_p;
    logic use_p;
    int n_fail = 0;
    int total_checks = 0;

    ilm_irq_source src (.mclk(mclk), .irq(irq));
    ilm_latency_meter #(.NUM_LINES(4)) DUT (.mclk(mclk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq));
    ilm_latency_meter #(.NUM_LINES(4), .PULSE_MODE(1)) DUT_P (.mclk(mclk), .reset(reset),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata_p), .waitrequest(waitrequest_p), .irq(irq));

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One access; request held until waitrequest seen low, dropped after that cycle
    task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        int i;
        @(negedge mclk);
        address = a;
        writedata = d;
        write = wr;
        read = !wr;
        i = 0;
        do begin
            @(negedge mclk);
            i++;
        end while (waitrequest !== 1'b0 && i < 8);
        if (waitrequest !== 1'b0) begin
            n_fail++;
            $display("MISMATCH %0t bus hang", $time);
            test_done();
        end
        q = use_p ? readdata_p : readdata;
        if (use_p) chk({31'h0, waitrequest_p}, 32'h0);
        @(negedge mclk);
        read = 1'b0;
        write = 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        access(1'b1, a, d, rdata);
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0, rdata);
        chk(rdata, exp);
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    initial begin
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0;
        use_p = 1'b0;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        rchk(CTL, 32'h0000_0110);
        rchk(FRQ, 32'h02fa_f080);
        rchk(VLD, 32'h0);
        rchk(6'h00, 32'h0);
        $display("test reset_values done");
        // Rise while disabled is ignored
        src.pulse(0, 6);
        repeat (4) @(negedge mclk);
        rchk(VLD, 32'h0);
        wr(CTL, 32'hffff_fffe);
        rchk(CTL, 32'h0000_0110);
        wr(CTL, 32'hffff_ffff);
        rchk(CTL, 32'h0000_0111);
        wr(FRQ, 32'h0);
        rchk(FRQ, 32'h02fa_f080);
        $display("test control done");
        src.pulse(1, 10);
        repeat (4) @(negedge mclk);
        rchk(VLD, 32'h0000_0002);
        rchk(6'h01, 32'd9);
        rchk(VLD, 32'h0);
        src.pulse(1, 5);
        repeat (4) @(negedge mclk);
        rchk(6'h01, 32'd4);
        $display("test level_measure done");
        // Halt written mid-measurement must not stop a level counter
        fork
            src.pulse(2, 20);
            begin
                repeat (3) @(negedge mclk);
                rchk(ACT, 32'h0000_0004);
                wr(HLT, 32'h0000_0005);
                rchk(HLT, 32'h0000_0005);
            end
        join
        repeat (4) @(negedge mclk);
        rchk(6'h02, 32'd19);
        $display("test halt_level done");
        fork
            src.pulse(3, 3);
            src.pulse(5, 3);
        join
        repeat (4) @(negedge mclk);
        rchk(VLD, 32'h0000_0008);
        rchk(6'h03, 32'd2);
        rchk(6'h05, 32'h0);
        rchk(6'h25, 32'h0);
        rchk(ACT, 32'h0);
        $display("test unconfigured done");
        // Pulse copy: the halt bit edge ends the count, level copy ignores it
        wr(HLT, 32'h0);
        fork
            src.pulse(0, 2);
            begin
                repeat (5) @(negedge mclk);
                wr(HLT, 32'h0000_0001);
            end
        join
        repeat (4) @(negedge mclk);
        use_p = 1'b1;
        rchk(VLD, 32'h0000_0001);
        rchk(6'h00, 32'd5);
        rchk(ACT, 32'h0000_000a);
        use_p = 1'b0;
        rchk(6'h00, 32'd1);
        $display("test pulse_measure done");
        test_done();
    end
endmodule
`default_nettype wire
